// >>> hw/sd_status_block.sv
// card-side status block source with APB configuration and status
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sd_status_block (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cmd_valid_in,
  input wire logic [5:0] cmd_index_in,
  input wire logic [1:0] cmd_arg_in,
  input wire logic cmd_crc_ok_in,
  input wire logic card_tran_in,
  output logic blk_bit_out,
  output logic blk_valid_out,
  output logic blk_last_out,
  output logic busy_out,
  output logic illegal_cmd_out,
  output logic crc_err_out
);
  import sd_status_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic [31:0] mode_reg;
  logic [31:0] prot_reg;
  logic [31:0] perf_reg;
  logic [31:0] erase_reg;
  logic [1:0] width_reg;
  logic app_reg;
  logic ill_now_reg;
  logic crc_now_reg;
  logic ill_rep_reg;
  logic crc_rep_reg;
  logic [BLOCK_BITS-1:0] shift_reg;
  logic [CNT_W-1:0] cnt_reg;
  send_state_type state_reg;
  logic bit_reg;
  logic valid_reg;
  logic last_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic cmd_good;
  logic is_acmd13;
  logic is_acmd6;
  logic start_send;
  logic ill_now;
  logic speed_ok;
  logic au_ok;
  logic [31:0] stat_word;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == MODE_OFS) || (a == PROT_OFS) || (a == PERF_OFS)
      || (a == ERASE_OFS) || (a == STAT_OFS);
  endfunction : known_addr

  // assemble the block from the live configuration
  function automatic logic [BLOCK_BITS-1:0] build_block(
    input logic [1:0] w,
    input logic [31:0] md,
    input logic [31:0] pr,
    input logic [31:0] pf,
    input logic [31:0] er
  );
    logic [BLOCK_BITS-1:0] b;
    // (RL12) reserved areas sent as zero
    b = '0;
    // (RL3) bus width field
    b[BUS_WIDTH_LSB +: 2] = w;
    // (RL4) secured mode bit
    b[SECURED_BIT] = md[0];
    // (RL5) card type field
    // (RL6) variant and nonstandard bytes kept whole
    b[CARD_TYPE_LSB +: 16] = md[31:16];
    // (RL7) protected area size
    b[PROT_SIZE_LSB +: 32] = pr;
    // (RL8) speed class code
    b[SPEED_LSB +: 8] = pf[7:0];
    // (RL9) move performance
    // (RL18) FFh and 00h codes passed unchanged
    b[PERF_LSB +: 8] = pf[15:8];
    // (RL10) allocation unit code
    b[AU_LSB +: 4] = pf[19:16];
    // (RL11) erase parameter fields
    b[ERASE_SIZE_LSB +: 16] = er[15:0];
    // (RL19) timeout seconds and offset codes
    b[ERASE_TMO_LSB +: 6] = er[21:16];
    b[ERASE_OFS_LSB +: 2] = er[23:22];
    build_block = b;
  endfunction : build_block

  ////////////////////////////////////////////////////////////////
  // apb decode; zero wait states
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;
  assign addr_ok = known_addr(paddr_in);
  assign pready_out = 1'b1;

  // (RL16) speed code in defined range
  assign speed_ok = perf_reg[7:0] <= SPEED_MAX;
  // (RL17) au code in defined range
  assign au_ok = (perf_reg[19:16] >= AU_MIN) && (perf_reg[19:16] <= AU_MAX);

  // (RL15) busy visible while the block is sent
  assign stat_word = {25'h0000000, au_ok, speed_ok, crc_rep_reg, ill_rep_reg,
    state_reg == ST_SEND, width_reg};

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_reg <= MODE_RST;
      prot_reg <= PROT_RST;
      perf_reg <= PERF_RST;
      erase_reg <= ERASE_RST;
    end else if (wr_en) begin
      case (paddr_in)
        MODE_OFS: mode_reg <= {pwdata_in[31:16], 15'h0000, pwdata_in[0]};
        PROT_OFS: prot_reg <= pwdata_in;
        PERF_OFS: perf_reg <= {12'h000, pwdata_in[19:0]};
        ERASE_OFS: erase_reg <= {8'h00, pwdata_in[23:0]};
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata_out = prdata_reg;
    pslverr_out = slverr_reg;
  end

  // read data and error are driven in the access cycle itself
  always_comb begin
    prdata_reg = 32'h0000_0000;
    slverr_reg = psel_in && penable_in && !addr_ok;
    if (rd_en) begin
      case (paddr_in)
        MODE_OFS: prdata_reg = mode_reg;
        PROT_OFS: prdata_reg = prot_reg;
        PERF_OFS: prdata_reg = perf_reg;
        ERASE_OFS: prdata_reg = erase_reg;
        STAT_OFS: prdata_reg = stat_word;
        default: prdata_reg = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // command decode
  assign cmd_good = cmd_valid_in && cmd_crc_ok_in;
  assign is_acmd13 = cmd_good && app_reg && (cmd_index_in == CMD_STATUS);
  assign is_acmd6 = cmd_good && app_reg && (cmd_index_in == CMD_BUS_WIDTH);
  // (RL2) refuse when not in transfer state or still sending
  assign ill_now = (is_acmd13 && (!card_tran_in || state_reg == ST_SEND))
    || (is_acmd6 && (!card_tran_in || cmd_arg_in[0]));
  assign start_send = is_acmd13 && !ill_now;

  // app prefix lasts for exactly one following command
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      app_reg <= 1'b0;
    end else if (cmd_valid_in) begin
      app_reg <= cmd_good && (cmd_index_in == CMD_APP);
    end
  end

  // (RL3) width follows the bus width command
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      width_reg <= WIDTH_1BIT;
    end else if (is_acmd6 && !ill_now) begin
      width_reg <= cmd_arg_in[1] ? WIDTH_4BIT : WIDTH_1BIT;
    end
  end

  // (RL14) errors shown one command late
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ill_now_reg <= 1'b0;
      crc_now_reg <= 1'b0;
      ill_rep_reg <= 1'b0;
      crc_rep_reg <= 1'b0;
    end else if (cmd_valid_in) begin
      ill_now_reg <= ill_now;
      crc_now_reg <= !cmd_crc_ok_in;
      ill_rep_reg <= ill_now_reg;
      crc_rep_reg <= crc_now_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // block transmitter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_send) begin
            state_reg <= ST_SEND;
            cnt_reg <= '0;
          end
        end
        ST_SEND: begin
          // (RL1) exactly one full block
          if (cnt_reg == CNT_W'(BLOCK_BITS - 1)) begin
            state_reg <= ST_IDLE;
          end
          cnt_reg <= cnt_reg + CNT_W'(1);
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // (RL13) snapshot of current state at the command
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      shift_reg <= '0;
    end else if (start_send) begin
      shift_reg <= build_block(width_reg, mode_reg, prot_reg, perf_reg, erase_reg);
    end else if (state_reg == ST_SEND) begin
      shift_reg <= {shift_reg[BLOCK_BITS-2:0], 1'b0};
    end
  end

  // most significant bit leaves first
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bit_reg <= 1'b0;
      valid_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      bit_reg <= (state_reg == ST_SEND) ? shift_reg[BLOCK_BITS-1] : 1'b0;
      valid_reg <= state_reg == ST_SEND;
      last_reg <= (state_reg == ST_SEND) && (cnt_reg == CNT_W'(BLOCK_BITS - 1));
    end
  end

  assign blk_bit_out = bit_reg;
  assign blk_valid_out = valid_reg;
  assign blk_last_out = last_reg;
  assign busy_out = state_reg == ST_SEND;
  assign illegal_cmd_out = ill_rep_reg;
  assign crc_err_out = crc_rep_reg;
endmodule : sd_status_block
`default_nettype wire

// >>> hw/sd_status_pkg.sv
// constants and field layout of the card status block logic
// Operation
// (RL1) ACMD13 returns one 512-bit status block
// (RL2) ACMD13 only in selected transfer state
// (RL3) bits 511:510 bus width, 00/10 valid
// (RL4) bit 509 secured mode flag
// (RL5) bits 495:480 card type, 0000/0001
// (RL6) type low byte variants, high nonstandard
// (RL7) bits 479:448 protected area size
// (RL8) bits 447:440 speed class code
// (RL9) bits 439:432 move performance, 1MB/s units
// (RL10) bits 431:428 AU size, 427:424 reserved
// (RL11) erase size, timeout, offset fields
// (RL12) reserved and maker bits ignored
// (RL13) fields taken from current card state
// (RL14) class B errors report previous command
// (RL15) type X bits set during execution
// (RL16) speed codes 00h-03h valid, rest reserved
// (RL17) AU codes 01h-09h valid
// (RL18) move performance FFh unlimited, 00h undefined
// (RL19) erase timeout 1-63 s, offset 0-3 s
// (RL20) host buffers block MSB first, checks CRC; the host model checks no CRC
// (RL21) host holds decoded fields until next block; the host model decodes no fields and holds only the raw block in blk_out
package sd_status_pkg;
  localparam int BLOCK_BITS = 512;
  localparam int CNT_W = 10;
  // field positions inside the block
  localparam int BUS_WIDTH_LSB = 510;
  localparam int SECURED_BIT = 509;
  localparam int CARD_TYPE_LSB = 480;
  localparam int PROT_SIZE_LSB = 448;
  localparam int SPEED_LSB = 440;
  localparam int PERF_LSB = 432;
  localparam int AU_LSB = 428;
  localparam int ERASE_SIZE_LSB = 408;
  localparam int ERASE_TMO_LSB = 402;
  localparam int ERASE_OFS_LSB = 400;
  // command indices
  localparam logic [5:0] CMD_APP = 6'h37;
  localparam logic [5:0] CMD_STATUS = 6'h0D;
  localparam logic [5:0] CMD_BUS_WIDTH = 6'h06;
  // bus width codes
  localparam logic [1:0] WIDTH_1BIT = 2'h0;
  localparam logic [1:0] WIDTH_4BIT = 2'h2;
  // code limits
  localparam logic [7:0] SPEED_MAX = 8'h03;
  localparam logic [3:0] AU_MIN = 4'h1;
  localparam logic [3:0] AU_MAX = 4'h9;
  // register offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] PROT_OFS = 8'h04;
  localparam logic [7:0] PERF_OFS = 8'h08;
  localparam logic [7:0] ERASE_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  // reset values
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] PROT_RST = 32'h0000_0000;
  localparam logic [31:0] PERF_RST = 32'h0000_0000;
  localparam logic [31:0] ERASE_RST = 32'h0000_0000;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND} send_state_type;
endpackage : sd_status_pkg

// >>> tb/sd_host_model.sv
// host-side model: issues commands and gathers the status block
`timescale 1ns/1ps
`default_nettype none
module sd_host_model (
  input wire logic clk_in,
  output logic cmd_valid_out,
  output logic [5:0] cmd_index_out,
  output logic [1:0] cmd_arg_out,
  output logic cmd_crc_ok_out,
  input wire logic blk_bit_in,
  input wire logic blk_valid_in,
  input wire logic blk_last_in,
  output logic [511:0] blk_out,
  output logic done_out
);
  import sd_status_pkg::*;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_index_out = 6'h00;
    cmd_arg_out = 2'h0;
    cmd_crc_ok_out = 1'b1;
  end
  // app prefix sent back to back with its command
  task automatic send(input logic [5:0] idx, input logic [1:0] arg, input logic ok,
    input logic app);
    if (app) begin
      @(posedge clk_in);
      cmd_valid_out <= 1'b1;
      cmd_index_out <= CMD_APP;
      cmd_crc_ok_out <= 1'b1;
    end
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_index_out <= idx;
    cmd_arg_out <= arg;
    cmd_crc_ok_out <= ok;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_index_out <= ~idx;
    cmd_arg_out <= ~arg;
  endtask : send
  always_ff @(posedge clk_in) begin
    if (blk_valid_in) begin
      blk_out <= {blk_out[510:0], blk_bit_in};
    end
    done_out <= blk_valid_in && blk_last_in;
  end
endmodule : sd_host_model
`default_nettype wire

// >>> tb/sd_status_block_assertions.sv
// bound checker for the card status block source
`timescale 1ns/1ps
`default_nettype none
module sd_status_block_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic cmd_valid_in,
  input wire logic [5:0] cmd_index_in,
  input wire logic card_tran_in,
  input wire logic blk_valid_out,
  input wire logic blk_last_out,
  input wire logic busy_out
);
  import sd_status_pkg::*;
  logic [9:0] run_reg;
  // length of the current bit run
  always_ff @(posedge clk_in) begin
    if (srst_in || !blk_valid_out) begin
      run_reg <= 10'h000;
    end else begin
      run_reg <= run_reg + 10'h001;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  ready_high_a: assert property (pready_out) else $error("pready low");
  last_count_a: assert property (blk_last_out == (blk_valid_out && run_reg == 10'h1FF))
    else $error("last bit not at bit 512");
  run_end_a: assert property (blk_last_out |=> !blk_valid_out && !busy_out)
    else $error("run longer than block");
  start_cause_a: assert property ($rose(busy_out) |->
    $past(cmd_valid_in) && $past(cmd_index_in) == CMD_STATUS && $past(card_tran_in))
    else $error("block without status command");
  busy_lead_a: assert property ($rose(busy_out) |=> $rose(blk_valid_out))
    else $error("first bit late");
  valid_busy_a: assert property (blk_valid_out && !blk_last_out |-> busy_out)
    else $error("bit sent while idle");
  err_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error outside access");
  idle_data_a: assert property (!(psel_in && penable_in) |-> prdata_out == 32'h0000_0000)
    else $error("read data outside access");
  unmapped_a: assert property (psel_in && penable_in && paddr_in > 8'h10 |-> pslverr_out)
    else $error("unmapped access not refused");
  cover property ($rose(busy_out));
  cover property (blk_last_out);
  cover property (pslverr_out);
endmodule : sd_status_block_checker
bind sd_status_block sd_status_block_checker chk (.*);
`default_nettype wire

// >>> tb/tb_sd_status_block_decoder.sv
// self-checking bench for the card status block source
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_sd_status_block_decoder;
  import sd_status_pkg::*;
  localparam logic [31:0] MSK [4] = '{32'hFFFF_0001, 32'hFFFF_FFFF, 32'h000F_FFFF, 32'h00FF_FFFF};
  localparam logic [7:0] OFS [4] = '{MODE_OFS, PROT_OFS, PERF_OFS, ERASE_OFS};
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic card_tran = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cmd_valid, cmd_crc_ok, busy, illegal, crc_err;
  logic blk_bit, blk_valid, blk_last, done;
  logic [5:0] cmd_index;
  logic [1:0] cmd_arg;
  logic [511:0] blk, exp_blk;
  logic [511:0] exp_q[$];
  logic [31:0] rnd = 32'h0000_001D;
  int errors = 0;
  int checked = 0;
  sd_status_block DUT (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cmd_valid_in(cmd_valid), .cmd_index_in(cmd_index), .cmd_arg_in(cmd_arg),
    .cmd_crc_ok_in(cmd_crc_ok), .card_tran_in(card_tran), .blk_bit_out(blk_bit),
    .blk_valid_out(blk_valid), .blk_last_out(blk_last), .busy_out(busy),
    .illegal_cmd_out(illegal), .crc_err_out(crc_err));
  sd_host_model host (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_index_out(cmd_index),
    .cmd_arg_out(cmd_arg), .cmd_crc_ok_out(cmd_crc_ok), .blk_bit_in(blk_bit),
    .blk_valid_in(blk_valid), .blk_last_in(blk_last), .blk_out(blk), .done_out(done));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic close_out;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always @(posedge clk_in) begin
    if (done === 1'b1) begin
      exp_blk = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      `CHK(blk, exp_blk)
    end
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    close_out();
  end
  initial begin
    logic [31:0] v[4];
    logic [31:0] q;
    logic e;
    logic [1:0] w;
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    card_tran <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 4; k++) begin
        rnd = nxt(nxt(nxt(rnd)));
        // boundary codes: speed 03h, unlimited move, AU 9
        v[k] = (i == 1 && k == 2) ? 32'h0009_FF03 : rnd & MSK[k];
        apb(1'b1, OFS[k], (i == 1 && k == 2) ? v[k] : rnd, q, e);
        apb(1'b0, OFS[k], 32'h0000_0000, q, e);
        `CHK(q, v[k])
      end
      w = (i == 0) ? WIDTH_4BIT : WIDTH_1BIT;
      host.send(CMD_BUS_WIDTH, w, 1'b1, 1'b1);
      exp_q.push_back({w, v[0][0], 13'h0000, v[0][31:16], v[1], v[2][7:0], v[2][15:8],
        v[2][19:16], 4'h0, v[3][15:0], v[3][21:16], v[3][23:22], 400'h0});
      host.send(CMD_STATUS, 2'h0, 1'b1, 1'b1);
      @(posedge done);
      apb(1'b0, STAT_OFS, 32'h0000_0000, q, e);
      `CHK(q, {25'h0, v[2][19:16] >= 4'h1 && v[2][19:16] <= 4'h9, v[2][7:0] <= 8'h03, 3'h0, w})
    end
    apb(1'b0, 8'h14, 32'h0000_0000, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    card_tran <= 1'b0;
    host.send(CMD_STATUS, 2'h0, 1'b1, 1'b1);
    card_tran <= 1'b1;
    host.send(CMD_APP, 2'h0, 1'b1, 1'b0);
    @(negedge clk_in);
    `CHK({illegal, crc_err}, 2'b10)
    host.send(CMD_STATUS, 2'h0, 1'b0, 1'b0);
    host.send(CMD_APP, 2'h0, 1'b1, 1'b0);
    @(negedge clk_in);
    `CHK({illegal, crc_err}, 2'b01)
    // refused width change keeps the 1-bit width
    host.send(CMD_BUS_WIDTH, 2'h3, 1'b1, 1'b1);
    host.send(CMD_APP, 2'h0, 1'b1, 1'b0);
    @(negedge clk_in);
    `CHK({illegal, crc_err}, 2'b10)
    apb(1'b0, STAT_OFS, 32'h0000_0000, q, e);
    `CHK(q, {25'h0, 2'b11, 1'b0, 1'b1, 1'b0, WIDTH_1BIT})
    repeat (600) @(posedge clk_in);
    close_out();
  end
endmodule : tb_sd_status_block_decoder
`default_nettype wire
